// >>> rtl/sfs_flash_core.sv
`timescale 1ns/1ps
module sfs_flash_core #(
	parameter int unsigned P_TW_CYCLES = sfs_pkg::TW_CYC
) (
	// System side
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Serial link
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io_i,
	output logic [3:0] o_io_o,
	output logic [3:0] o_io_oe,
	input wire logic i_wp_n,
	// Array read port, link clock domain
	output logic [23:0] o_mem_addr,
	input wire logic [7:0] i_mem_data,
	// Status
	output logic [23:0] o_status
);

	localparam logic [sfs_pkg::TMR_W-1:0] TW_LAST = (sfs_pkg::TMR_W)'(P_TW_CYCLES - 1);

	if (P_TW_CYCLES < 1 || P_TW_CYCLES >= (2 ** sfs_pkg::TMR_W)) begin : g_chk_tw
		$error("P_TW_CYCLES out of range for the cycle timer");
	end

	sfs_pkg::sfs_sys_s sys_ff, nxt_sys;
	sfs_pkg::sfs_lnk_s lnk_ff, nxt_lnk;
	sfs_pkg::sfs_frm_s frm_ff, nxt_frm;
	sfs_pkg::sfs_out_s out_ff, nxt_out;

	logic frm_rst_n;

	// Frame logic is held cleared while chip select is high
	assign frm_rst_n = i_rst_n & ~i_cs_n;

	function automatic logic [4:0] grp_last(input sfs_pkg::sfs_lanes_e ln);
		logic [4:0] r;
		r = 5'h07;
		unique case (ln)
			sfs_pkg::LN_1: r = 5'h07;
			sfs_pkg::LN_2: r = 5'h03;
			sfs_pkg::LN_4: r = 5'h01;
			default: r = 5'h07;
		endcase
		return r;
	endfunction

	function automatic logic [3:0] grp_oe(input sfs_pkg::sfs_lanes_e ln);
		logic [3:0] r;
		r = 4'h2;
		unique case (ln)
			sfs_pkg::LN_1: r = 4'h2;
			sfs_pkg::LN_2: r = 4'h3;
			sfs_pkg::LN_4: r = 4'hF;
			default: r = 4'h2;
		endcase
		return r;
	endfunction

	// Bits of one clock group, byte sent MSB first
	function automatic logic [3:0] grp_bits(input logic [7:0] b, input logic [4:0] idx,
			input sfs_pkg::sfs_lanes_e ln);
		logic [7:0] s;
		logic [3:0] r;
		s = 8'h00;
		r = 4'h0;
		unique case (ln)
			sfs_pkg::LN_1: begin
				s = b << idx[2:0];
				r = {2'b00, s[7], 1'b0};
			end
			sfs_pkg::LN_2: begin
				s = b << {idx[1:0], 1'b0};
				r = {2'b00, s[7], s[6]};
			end
			sfs_pkg::LN_4: begin
				s = b << {idx[0], 2'b00};
				r = s[7:4];
			end
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	function automatic sfs_pkg::sfs_lanes_e data_lanes(input logic [7:0] op);
		sfs_pkg::sfs_lanes_e r;
		r = sfs_pkg::LN_1;
		if (op == sfs_pkg::OP_DUAL_OUT || op == sfs_pkg::OP_DUAL_IO) begin
			r = sfs_pkg::LN_2;
		end else if (op == sfs_pkg::OP_QUAD_OUT) begin
			r = sfs_pkg::LN_4;
		end
		return r;
	endfunction

	// ---------------- Link domain, rising edge ----------------
	logic [7:0] op_full;
	logic [7:0] mode_full;
	logic [4:0] addr_last;
	logic link_busy;

	always_comb begin
		nxt_frm = frm_ff;
		nxt_lnk = lnk_ff;
		op_full = {frm_ff.op[6:0], i_io_i[0]};
		mode_full = {frm_ff.mode[5:0], i_io_i[1:0]};
		addr_last = sfs_pkg::ADDR1_LAST;
		link_busy = lnk_ff.scopy[sfs_pkg::ST_BUSY];
		// Status word handshake from the system domain
		nxt_lnk.req_sync = {lnk_ff.req_sync[0], sys_ff.req};
		if (lnk_ff.req_sync[1] != lnk_ff.ack) begin
			nxt_lnk.scopy = sys_ff.pub;
			nxt_lnk.ack = lnk_ff.req_sync[1];
		end
		unique case (frm_ff.phase)
			sfs_pkg::PH_OP: begin
				if (frm_ff.cnt == 5'h00) begin
					nxt_lnk.res_valid = 1'b0;
					nxt_lnk.res_wbits = 4'h0;
				end
				if (frm_ff.cnt == 5'h00 && lnk_ff.cont) begin
					// Opcode skipped, first address pair already here
					nxt_frm.op = sfs_pkg::OP_DUAL_IO;
					nxt_frm.addr = {22'h000000, i_io_i[1:0]};
					nxt_frm.cnt = 5'h01;
					nxt_frm.lanes = sfs_pkg::LN_2;
					nxt_frm.phase = link_busy ? sfs_pkg::PH_IGN : sfs_pkg::PH_ADDR;
				end else if (frm_ff.cnt == sfs_pkg::OP_LAST) begin
					nxt_frm.op = op_full;
					nxt_frm.cnt = 5'h00;
					nxt_frm.lanes = sfs_pkg::LN_1;
					nxt_lnk.res_op = op_full;
					nxt_lnk.res_valid = 1'b1;
					unique case (op_full)
						sfs_pkg::OP_READ, sfs_pkg::OP_FAST_READ, sfs_pkg::OP_DUAL_OUT,
						sfs_pkg::OP_QUAD_OUT, sfs_pkg::OP_DUAL_IO: begin
							nxt_frm.phase = link_busy ? sfs_pkg::PH_IGN : sfs_pkg::PH_ADDR;
							nxt_frm.lanes = data_lanes(op_full);
						end
						sfs_pkg::OP_STAT_RD_LO, sfs_pkg::OP_STAT_RD_MID,
						sfs_pkg::OP_STAT_RD_HI: begin
							nxt_frm.phase = sfs_pkg::PH_STAT;
						end
						sfs_pkg::OP_STAT_WR_LO, sfs_pkg::OP_STAT_WR_MID,
						sfs_pkg::OP_STAT_WR_HI: begin
							nxt_frm.phase = sfs_pkg::PH_WDATA;
						end
						sfs_pkg::OP_CONT_RST: begin
							nxt_lnk.cont = 1'b0;
							nxt_frm.phase = sfs_pkg::PH_IGN;
						end
						default: begin
							nxt_frm.phase = sfs_pkg::PH_IGN;
						end
					endcase
				end else begin
					nxt_frm.op = op_full;
					nxt_frm.cnt = frm_ff.cnt + 5'h01;
				end
			end
			sfs_pkg::PH_ADDR: begin
				if (frm_ff.op == sfs_pkg::OP_DUAL_IO) begin
					nxt_frm.addr = {frm_ff.addr[21:0], i_io_i[1:0]};
					addr_last = sfs_pkg::ADDR2_LAST;
				end else begin
					nxt_frm.addr = {frm_ff.addr[22:0], i_io_i[0]};
				end
				if (frm_ff.cnt == addr_last) begin
					nxt_frm.cnt = 5'h00;
					if (frm_ff.op == sfs_pkg::OP_READ) begin
						nxt_frm.phase = sfs_pkg::PH_DATA;
					end else if (frm_ff.op == sfs_pkg::OP_DUAL_IO) begin
						nxt_frm.phase = sfs_pkg::PH_MODE;
					end else begin
						nxt_frm.phase = sfs_pkg::PH_DUMMY;
					end
				end else begin
					nxt_frm.cnt = frm_ff.cnt + 5'h01;
				end
			end
			sfs_pkg::PH_MODE: begin
				nxt_frm.mode = mode_full;
				if (frm_ff.cnt == sfs_pkg::MODE_LAST) begin
					nxt_lnk.cont = (mode_full[5:4] == sfs_pkg::CONT_KEY);
					nxt_frm.cnt = 5'h00;
					nxt_frm.phase = sfs_pkg::PH_DATA;
				end else begin
					nxt_frm.cnt = frm_ff.cnt + 5'h01;
				end
			end
			sfs_pkg::PH_DUMMY: begin
				// Line values are not looked at here
				if (frm_ff.cnt == sfs_pkg::DUMMY_LAST) begin
					nxt_frm.cnt = 5'h00;
					nxt_frm.phase = sfs_pkg::PH_DATA;
				end else begin
					nxt_frm.cnt = frm_ff.cnt + 5'h01;
				end
			end
			sfs_pkg::PH_DATA, sfs_pkg::PH_STAT: begin
				if (frm_ff.cnt == grp_last(frm_ff.lanes)) begin
					nxt_frm.cnt = 5'h00;
					if (frm_ff.phase == sfs_pkg::PH_DATA) begin
						nxt_frm.addr = frm_ff.addr + 24'h000001;
					end
				end else begin
					nxt_frm.cnt = frm_ff.cnt + 5'h01;
				end
			end
			sfs_pkg::PH_WDATA: begin
				nxt_lnk.res_wbyte = {lnk_ff.res_wbyte[6:0], i_io_i[0]};
				if (lnk_ff.res_wbits != sfs_pkg::WBITS_SAT) begin
					nxt_lnk.res_wbits = lnk_ff.res_wbits + 4'h1;
				end
			end
			sfs_pkg::PH_IGN: begin
			end
		endcase
	end

	always_ff @(posedge i_sclk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			frm_ff <= '{phase: sfs_pkg::PH_OP, op: 8'h00, cnt: 5'h00, addr: 24'h000000,
				mode: 8'h00, lanes: sfs_pkg::LN_1};
		end else begin
			frm_ff <= nxt_frm;
		end
	end

	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lnk_ff <= '{cont: 1'b0, scopy: sfs_pkg::STAT_RST, req_sync: 2'h0, ack: 1'b0,
				res_op: 8'h00, res_valid: 1'b0, res_wbits: 4'h0, res_wbyte: 8'h00};
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	// ---------------- Link domain, falling edge ----------------
	logic [7:0] stat_byte;
	logic [7:0] out_byte;

	always_comb begin
		nxt_out = out_ff;
		nxt_out.io_o = 4'h0;
		nxt_out.io_oe = 4'h0;
		if (frm_ff.op == sfs_pkg::OP_STAT_RD_MID) begin
			stat_byte = lnk_ff.scopy[15:8];
		end else if (frm_ff.op == sfs_pkg::OP_STAT_RD_HI) begin
			stat_byte = lnk_ff.scopy[23:16];
		end else begin
			stat_byte = lnk_ff.scopy[7:0];
		end
		out_byte = out_ff.byte_q;
		if (frm_ff.cnt == 5'h00) begin
			// Fresh byte each round; status repeats the same byte
			out_byte = (frm_ff.phase == sfs_pkg::PH_STAT) ? stat_byte : i_mem_data;
		end
		if (frm_ff.phase == sfs_pkg::PH_DATA || frm_ff.phase == sfs_pkg::PH_STAT) begin
			nxt_out.byte_q = out_byte;
			nxt_out.io_o = grp_bits(out_byte, frm_ff.cnt, frm_ff.lanes);
			nxt_out.io_oe = grp_oe(frm_ff.lanes);
		end
	end

	always_ff @(negedge i_sclk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			out_ff <= '{io_o: 4'h0, io_oe: 4'h0, byte_q: 8'h00};
		end else begin
			out_ff <= nxt_out;
		end
	end

	// ---------------- System domain ----------------
	logic cs_rise;
	logic locked;
	logic wr_ok;
	logic [23:0] wr_new;
	logic [23:0] wr_merged;

	always_comb begin
		nxt_sys = sys_ff;
		nxt_sys.cs_sync = {sys_ff.cs_sync[0], i_cs_n};
		nxt_sys.cs_prev = sys_ff.cs_sync[1];
		nxt_sys.wp_sync = {sys_ff.wp_sync[0], i_wp_n};
		nxt_sys.ack_sync = {sys_ff.ack_sync[0], lnk_ff.ack};
		cs_rise = sys_ff.cs_sync[1] & ~sys_ff.cs_prev;
		// Lock bit 1, or lock bit 0 with protect pin low
		locked = sys_ff.stat[sfs_pkg::ST_LOCK1] |
			(sys_ff.stat[sfs_pkg::ST_LOCK0] & ~sys_ff.wp_sync[1]);
		wr_ok = (lnk_ff.res_wbits == sfs_pkg::WBITS_FULL) && !locked;
		wr_new = sys_ff.stat;
		if (lnk_ff.res_op == sfs_pkg::OP_STAT_WR_MID) begin
			wr_new[15:8] = lnk_ff.res_wbyte;
		end else if (lnk_ff.res_op == sfs_pkg::OP_STAT_WR_HI) begin
			wr_new[23:16] = lnk_ff.res_wbyte;
		end else begin
			wr_new[7:0] = lnk_ff.res_wbyte;
		end
		wr_merged = (wr_new & ~sfs_pkg::STAT_KEEP) | (sys_ff.stat & sfs_pkg::STAT_KEEP);
		if (sys_ff.busy) begin
			if (sys_ff.tmr == TW_LAST) begin
				nxt_sys.stat = sys_ff.pend;
				nxt_sys.stat[sfs_pkg::ST_BUSY] = 1'b0;
				nxt_sys.stat[sfs_pkg::ST_LATCH] = 1'b0;
				nxt_sys.busy = 1'b0;
				nxt_sys.tmr = '0;
			end else begin
				nxt_sys.tmr = sys_ff.tmr + 1'b1;
			end
		end
		if (cs_rise) begin
			nxt_sys.vol_arm = lnk_ff.res_valid && (lnk_ff.res_op == sfs_pkg::OP_VOL_WR_EN);
			if (lnk_ff.res_valid && !sys_ff.busy) begin
				unique case (lnk_ff.res_op)
					sfs_pkg::OP_WR_LATCH_SET: begin
						nxt_sys.stat[sfs_pkg::ST_LATCH] = 1'b1;
					end
					sfs_pkg::OP_WR_LATCH_CLR: begin
						nxt_sys.stat[sfs_pkg::ST_LATCH] = 1'b0;
					end
					sfs_pkg::OP_STAT_WR_LO, sfs_pkg::OP_STAT_WR_MID,
					sfs_pkg::OP_STAT_WR_HI: begin
						if (wr_ok && sys_ff.vol_arm) begin
							// Volatile copy updates at once, latch untouched
							nxt_sys.stat = wr_merged;
						end else if (wr_ok && sys_ff.stat[sfs_pkg::ST_LATCH]) begin
							nxt_sys.pend = wr_merged;
							nxt_sys.busy = 1'b1;
							nxt_sys.tmr = '0;
							nxt_sys.stat[sfs_pkg::ST_BUSY] = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// Publish status to the link side, one word per handshake
		if (sys_ff.pub != sys_ff.stat && sys_ff.req == sys_ff.ack_sync[1]) begin
			nxt_sys.pub = sys_ff.stat;
			nxt_sys.req = ~sys_ff.req;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sys_ff <= '{cs_sync: 2'h3, cs_prev: 1'b1, wp_sync: 2'h3, stat: sfs_pkg::STAT_RST,
				pend: sfs_pkg::STAT_RST, busy: 1'b0, tmr: '0, vol_arm: 1'b0,
				pub: sfs_pkg::STAT_RST, req: 1'b0, ack_sync: 2'h0};
		end else if (i_ce) begin
			sys_ff <= nxt_sys;
		end
	end

	assign o_io_o = out_ff.io_o;
	assign o_io_oe = out_ff.io_oe;
	assign o_mem_addr = frm_ff.addr;
	assign o_status = sys_ff.stat;

endmodule

// >>> rtl/sfs_pkg.sv
package sfs_pkg;

	// Command codes
	localparam logic [7:0] OP_WR_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_WR_LATCH_CLR = 8'h04;
	localparam logic [7:0] OP_VOL_WR_EN = 8'h50;
	localparam logic [7:0] OP_STAT_RD_LO = 8'h05;
	localparam logic [7:0] OP_STAT_RD_MID = 8'h35;
	localparam logic [7:0] OP_STAT_RD_HI = 8'h15;
	localparam logic [7:0] OP_STAT_WR_LO = 8'h01;
	localparam logic [7:0] OP_STAT_WR_MID = 8'h31;
	localparam logic [7:0] OP_STAT_WR_HI = 8'h11;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_CONT_RST = 8'hFF;

	// Status word layout
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_LATCH = 1;
	localparam int unsigned ST_LOCK0 = 7;
	localparam int unsigned ST_LOCK1 = 8;
	localparam logic [23:0] STAT_RST = 24'h000000;
	localparam logic [23:0] STAT_KEEP = 24'h9F8403;
	localparam logic [1:0] CONT_KEY = 2'h2;

	// Self-timed status write cycle
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned TW_NS = 5000000;
	localparam int unsigned TW_CYC = (TW_NS / CLK_NS) < 1 ? 1 : (TW_NS / CLK_NS);
	localparam int unsigned TMR_W = 24;

	// Phase lengths, last count value of each; write data phase as full and saturating bit counts
	localparam logic [4:0] OP_LAST = 5'h07;
	localparam logic [4:0] ADDR1_LAST = 5'h17;
	localparam logic [4:0] ADDR2_LAST = 5'h0B;
	localparam logic [4:0] DUMMY_LAST = 5'h07;
	localparam logic [4:0] MODE_LAST = 5'h03;
	localparam logic [3:0] WBITS_FULL = 4'h8;
	localparam logic [3:0] WBITS_SAT = 4'hF;

	typedef enum logic [2:0] {
		PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_STAT, PH_WDATA, PH_IGN
	} sfs_phase_e;

	typedef enum logic [1:0] {LN_1, LN_2, LN_4} sfs_lanes_e;

	// System clock domain
	typedef struct packed {
		logic [1:0] cs_sync;
		logic cs_prev;
		logic [1:0] wp_sync;
		logic [23:0] stat;
		logic [23:0] pend;
		logic busy;
		logic [TMR_W-1:0] tmr;
		logic vol_arm;
		logic [23:0] pub;
		logic req;
		logic [1:0] ack_sync;
	} sfs_sys_s;

	// Link domain, survives chip select high
	typedef struct packed {
		logic cont;
		logic [23:0] scopy;
		logic [1:0] req_sync;
		logic ack;
		logic [7:0] res_op;
		logic res_valid;
		logic [3:0] res_wbits;
		logic [7:0] res_wbyte;
	} sfs_lnk_s;

	// Link domain, cleared by chip select high
	typedef struct packed {
		sfs_phase_e phase;
		logic [7:0] op;
		logic [4:0] cnt;
		logic [23:0] addr;
		logic [7:0] mode;
		sfs_lanes_e lanes;
	} sfs_frm_s;

	// Falling-edge output stage
	typedef struct packed {
		logic [3:0] io_o;
		logic [3:0] io_oe;
		logic [7:0] byte_q;
	} sfs_out_s;

endpackage

// >>> verification/sfs_flash_core_props.sv
`timescale 1ns/1ps
module sfs_core_props #(
	parameter int unsigned P_TW_CYCLES = 10
) (
	// Watched ports
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io_i,
	input wire logic [3:0] o_io_o,
	input wire logic [3:0] o_io_oe,
	input wire logic i_wp_n,
	input wire logic [23:0] o_mem_addr,
	input wire logic [7:0] i_mem_data,
	input wire logic [23:0] o_status
);
	logic [23:0] busy_cnt_ff;
	// Enabled clocks spent busy
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_cnt_ff <= 24'h000000;
		end else if (!o_status[0]) begin
			busy_cnt_ff <= 24'h000000;
		end else if (i_ce) begin
			busy_cnt_ff <= busy_cnt_ff + 24'h000001;
		end
	end
	property p_idle_quiet;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cs_n && $past(i_cs_n) |-> (o_io_oe == 4'h0) && (o_mem_addr == 24'h000000);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("outputs active while deselected");
	property p_keep_bits;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_status & 24'h9F8400) == 24'h000000;
	endproperty
	a_keep_bits: assert property (p_keep_bits)
		else $error("fixed status bits changed");
	property p_wip_len;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		$fell(o_status[0]) |-> (busy_cnt_ff >= P_TW_CYCLES - 2) && (busy_cnt_ff <= P_TW_CYCLES + 2);
	endproperty
	a_wip_len: assert property (p_wip_len)
		else $error("write cycle length wrong");
	property p_latch_end;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		$fell(o_status[0]) |-> !o_status[1];
	endproperty
	a_latch_end: assert property (p_latch_end)
		else $error("latch flag not cleared at cycle end");
	property p_wip_start;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(o_status[0]) |-> i_cs_n && $past(i_cs_n);
	endproperty
	a_wip_start: assert property (p_wip_start)
		else $error("write cycle started while selected");
	property p_lock_freeze;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		$past(o_status[8]) && o_status[8] |-> $stable(o_status[23:2]);
	endproperty
	a_lock_freeze: assert property (p_lock_freeze)
		else $error("status changed while locked");
	property p_oe_lanes;
		@(negedge i_sclk) disable iff (!i_rst_n || i_cs_n)
		o_io_oe != 4'h0 |-> o_io_oe inside {4'h2, 4'h3, 4'hF};
	endproperty
	a_oe_lanes: assert property (p_oe_lanes)
		else $error("illegal output lane set");
	property p_addr_step;
		@(posedge i_sclk) disable iff (!i_rst_n || i_cs_n)
		(o_io_oe != 4'h0) && ($past(o_io_oe) != 4'h0) && (o_mem_addr != $past(o_mem_addr))
			|-> o_mem_addr == $past(o_mem_addr) + 24'h000001;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("read address did not step by one");
endmodule

bind sfs_flash_core sfs_core_props #(.P_TW_CYCLES(P_TW_CYCLES)) i_sfs_core_props (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_sclk(i_sclk),
	.i_cs_n(i_cs_n), .i_io_i(i_io_i), .o_io_o(o_io_o), .o_io_oe(o_io_oe),
	.i_wp_n(i_wp_n), .o_mem_addr(o_mem_addr), .i_mem_data(i_mem_data), .o_status(o_status)
);

// >>> verification/sfs_host_model.sv
`timescale 1ns/1ps
module sfs_host_model (
	// Serial link
	output logic o_sclk,
	output logic o_cs_n,
	output logic [3:0] o_drv,
	// Resolved lines
	input wire logic [3:0] i_wire,
	input wire logic [3:0] i_oe
);
	logic oe_seen;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_drv = 4'h0;
		oe_seen = 1'b0;
	end
	task automatic open_frame();
		#37;
		o_cs_n = 1'b0;
		oe_seen = 1'b0;
		#40;
	endtask
	// Change while low, taken on the rise; unused lines toggle
	task automatic put(input int lanes, input int nclk, input logic [31:0] bits);
		int k;
		logic [3:0] m;
		for (k = nclk - 1; k >= 0; k--) begin
			m = (4'h1 << lanes) - 4'h1;
			o_drv = (~o_drv & ~m) | (4'(bits >> (k * lanes)) & m);
			#40;
			o_sclk = 1'b1;
			#40;
			o_sclk = 1'b0;
		end
	endtask
	task automatic get(input int lanes, input int nbytes, output logic [63:0] data);
		int k;
		data = 64'h0;
		for (k = 0; k < nbytes * 8 / lanes; k++) begin
			o_drv = ~o_drv;
			#40;
			if (i_oe != 4'h0) begin
				oe_seen = 1'b1;
			end
			case (lanes)
				1: data = {data[62:0], i_wire[1]};
				2: data = {data[61:0], i_wire[1:0]};
				default: data = {data[59:0], i_wire};
			endcase
			o_sclk = 1'b1;
			#40;
			o_sclk = 1'b0;
		end
	endtask
	// Raised after whole units, deselect long enough for the status side
	task automatic close_frame();
		#20;
		o_cs_n = 1'b1;
		#700;
	endtask
endmodule

// >>> verification/tb_serial_flash_status_and_read_cmds.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; $display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb_serial_flash_status_and_read_cmds;
	localparam int P_TW = 200;
	logic i_clk_sys, i_rst_n, i_ce, i_wp_n, sclk, cs_n;
	logic [3:0] drv, io_o, io_oe, io_w;
	logic [23:0] mem_addr, status;
	logic [7:0] mem_data;
	int num_errors, n_checks, cycles;
	assign io_w = (io_oe & io_o) | (~io_oe & drv);
	assign mem_data = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
	sfs_flash_core #(.P_TW_CYCLES(P_TW)) i_sfs_flash_core (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_ce(i_ce), .i_sclk(sclk), .i_cs_n(cs_n), .i_io_i(io_w),
		.o_io_o(io_o), .o_io_oe(io_oe), .i_wp_n(i_wp_n), .o_mem_addr(mem_addr),
		.i_mem_data(mem_data), .o_status(status));
	sfs_host_model i_sfs_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_drv(drv),
		.i_wire(io_w), .i_oe(io_oe));
	initial i_clk_sys = 1'b0;
	always #50 i_clk_sys = ~i_clk_sys;
	function automatic logic [7:0] mexp(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	task automatic settle(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		i_sfs_host_model.open_frame();
		i_sfs_host_model.put(1, 8, {24'h0, op});
		i_sfs_host_model.close_frame();
	endtask
	task automatic swr(input logic [7:0] op, input logic [7:0] b, input int nbits);
		i_sfs_host_model.open_frame();
		i_sfs_host_model.put(1, 8, {24'h0, op});
		i_sfs_host_model.put(1, nbits, nbits > 8 ? {23'h0, b, 1'b0} : {24'h0, b} >> (8 - nbits));
		i_sfs_host_model.close_frame();
	endtask
	task automatic srd(input logic [7:0] op, input logic [7:0] ex);
		logic [63:0] d;
		i_sfs_host_model.open_frame();
		i_sfs_host_model.put(1, 8, {24'h0, op});
		i_sfs_host_model.get(1, 2, d);
		i_sfs_host_model.close_frame();
		`CHK("status byte", ex, d[15:8])
		`CHK("repeated byte", ex, d[7:0])
	endtask
	task automatic rd(input logic [7:0] op, input bit with_op, input logic [23:0] a,
		input logic [7:0] mode, input int n, input bit ok);
		int lanes;
		int i;
		logic [63:0] d;
		lanes = op == sfs_pkg::OP_QUAD_OUT ? 4 : (op == sfs_pkg::OP_DUAL_OUT || op == sfs_pkg::OP_DUAL_IO) ? 2 : 1;
		i_sfs_host_model.open_frame();
		if (with_op) begin
			i_sfs_host_model.put(1, 8, {24'h0, op});
		end
		if (op == sfs_pkg::OP_DUAL_IO) begin
			i_sfs_host_model.put(2, 12, {8'h0, a});
			i_sfs_host_model.put(2, 4, {24'h0, mode});
		end else begin
			i_sfs_host_model.put(1, 24, {8'h0, a});
			if (op != sfs_pkg::OP_READ) begin
				i_sfs_host_model.put(1, 8, 32'h0);
			end
		end
		i_sfs_host_model.get(lanes, n, d);
		i_sfs_host_model.close_frame();
		if (ok) begin
			for (i = 0; i < n; i++) begin
				`CHK("read byte", mexp(a + 24'(i)), d[8 * (n - 1 - i) +: 8])
			end
		end else begin
			`CHK("refused read drive", 1'b0, i_sfs_host_model.oe_seen)
		end
	endtask
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_wp_n = 1'b1;
		num_errors = 0;
		n_checks = 0;
		cycles = 0;
		settle(4);
		i_rst_n = 1'b1;
		settle(4);
		`CHK("status", 24'h000000, status)
		cmd(sfs_pkg::OP_WR_LATCH_SET);
		`CHK("status", 24'h000002, status)
		srd(sfs_pkg::OP_STAT_RD_LO, 8'h02);
		srd(sfs_pkg::OP_STAT_RD_MID, 8'h00);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'hFF, 8);
		`CHK("busy", 1'b1, status[0])
		srd(sfs_pkg::OP_STAT_RD_LO, 8'h03);
		rd(sfs_pkg::OP_READ, 1'b1, 24'h000010, 8'h00, 1, 1'b0);
		i_ce = 1'b0;
		settle(5);
		i_ce = 1'b1;
		settle(P_TW + 10);
		`CHK("status", 24'h0000FC, status)
		i_wp_n = 1'b0;
		cmd(sfs_pkg::OP_WR_LATCH_SET);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'h00, 8);
		settle(5);
		`CHK("status", 24'h0000FE, status)
		i_wp_n = 1'b1;
		swr(sfs_pkg::OP_STAT_WR_LO, 8'h00, 8);
		settle(P_TW + 10);
		`CHK("status", 24'h000000, status)
		cmd(sfs_pkg::OP_WR_LATCH_SET);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'hAA, 7);
		`CHK("status", 24'h000002, status)
		swr(sfs_pkg::OP_STAT_WR_LO, 8'hAA, 9);
		`CHK("status", 24'h000002, status)
		cmd(sfs_pkg::OP_WR_LATCH_CLR);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'h3C, 8);
		settle(5);
		`CHK("status", 24'h000000, status)
		cmd(sfs_pkg::OP_VOL_WR_EN);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'h1C, 8);
		settle(5);
		`CHK("status", 24'h00001C, status)
		cmd(sfs_pkg::OP_VOL_WR_EN);
		srd(sfs_pkg::OP_STAT_RD_LO, 8'h1C);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'h00, 8);
		settle(5);
		`CHK("status", 24'h00001C, status)
		cmd(sfs_pkg::OP_VOL_WR_EN);
		swr(sfs_pkg::OP_STAT_WR_HI, 8'hFF, 8);
		settle(5);
		`CHK("status", 24'h60001C, status)
		srd(sfs_pkg::OP_STAT_RD_HI, 8'h60);
		rd(sfs_pkg::OP_READ, 1'b1, 24'hFFFFFE, 8'h00, 3, 1'b1);
		rd(sfs_pkg::OP_FAST_READ, 1'b1, 24'h000123, 8'h00, 2, 1'b1);
		rd(sfs_pkg::OP_DUAL_OUT, 1'b1, 24'h0456FF, 8'h00, 2, 1'b1);
		rd(sfs_pkg::OP_QUAD_OUT, 1'b1, 24'h789A00, 8'h00, 2, 1'b1);
		rd(sfs_pkg::OP_DUAL_IO, 1'b1, 24'h00ABCD, 8'h20, 2, 1'b1);
		rd(sfs_pkg::OP_DUAL_IO, 1'b0, 24'h123456, 8'h00, 2, 1'b1);
		rd(sfs_pkg::OP_DUAL_IO, 1'b1, 24'h345678, 8'h20, 2, 1'b1);
		i_sfs_host_model.open_frame();
		i_sfs_host_model.put(2, 16, 32'hFFFFFFFF);
		i_sfs_host_model.close_frame();
		rd(sfs_pkg::OP_READ, 1'b1, 24'h000200, 8'h00, 2, 1'b1);
		cmd(sfs_pkg::OP_VOL_WR_EN);
		swr(sfs_pkg::OP_STAT_WR_MID, 8'h01, 8);
		settle(5);
		`CHK("status", 24'h60011C, status)
		cmd(sfs_pkg::OP_WR_LATCH_SET);
		swr(sfs_pkg::OP_STAT_WR_LO, 8'h00, 8);
		settle(P_TW + 10);
		`CHK("status", 24'h60011E, status)
		i_rst_n = 1'b0;
		settle(2);
		`CHK("status", 24'h000000, status)
		i_rst_n = 1'b1;
		settle(4);
		srd(sfs_pkg::OP_STAT_RD_LO, 8'h00);
		summarize();
	end
endmodule
